/* design/tdc_pkg.sv */
// package: descriptor layout, result codes and timing for the transfer descriptor codec
//
// Behaviour
// - descriptor header is eight bytes before payload
// - byte 1: status, active, toggle, count high
// - byte 5: limiter, direction, requested count high
// - too much received data reports 1000
// - short packet not filling buffer reports 1001
// - memory write too slow on IN reports 1100
// - memory read too slow on OUT reports 1101
// - completion clears active; inactive descriptors skipped
// - toggle holds expected data toggle, updated
// - ten-bit packet byte limit per packet
// - last flag one marks final list entry
// - speed bit zero means full speed
// - ten-bit requested byte count is transfer size
// - limiter bit resets to zero
// - limiter set: one transaction per frame for non-isochronous descriptors only
// - format zero non-isochronous, one isochronous
// - tokens use seven-bit target device address
package tdc_pkg;

    // ------------------------------------------------------------
    // header geometry
    // ------------------------------------------------------------
    localparam int HDR_BYTES = 8;
    localparam int HDR_BITS  = HDR_BYTES * 8;

    // bit positions within the 64-bit header, byte n at bits 8n+7:8n
    localparam int POS_DONE_LO   = 0;
    localparam int POS_DONE_HI   = 8;
    localparam int POS_ACTIVE    = 11;
    localparam int POS_TOGGLE    = 10;
    localparam int POS_STATUS    = 12;
    localparam int POS_LIMIT_LO  = 16;
    localparam int POS_LIMIT_HI  = 24;
    localparam int POS_SPEED     = 26;
    localparam int POS_LAST      = 27;
    localparam int POS_EP        = 28;
    localparam int POS_REQ_LO    = 32;
    localparam int POS_REQ_HI    = 40;
    localparam int POS_DIR       = 42;
    localparam int POS_ONCE      = 45;
    localparam int POS_ADDR      = 48;
    localparam int POS_FORMAT    = 55;

    // ------------------------------------------------------------
    // result codes and direction tokens
    // ------------------------------------------------------------
    localparam logic [3:0] RS_NO_ERROR   = 4'h0;
    localparam logic [3:0] RS_TOO_MUCH   = 4'h8;
    localparam logic [3:0] RS_SHORT      = 4'h9;
    localparam logic [3:0] RS_RSVD_A     = 4'hA;
    localparam logic [3:0] RS_RSVD_B     = 4'hB;
    localparam logic [3:0] RS_MEM_WR     = 4'hC;
    localparam logic [3:0] RS_MEM_RD     = 4'hD;

    typedef enum logic [1:0] {
        TDC_DIR_SETUP = 2'h0,
        TDC_DIR_OUT   = 2'h1,
        TDC_DIR_IN    = 2'h2,
        TDC_DIR_RSVD  = 2'h3
    } tdc_dir_e;

    // ------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------
    localparam int FRAME_US       = 1000;
    localparam int CLK_MHZ        = 250;
    localparam int FRAME_CYCLES   = FRAME_US * CLK_MHZ;
    localparam logic RST_ONCE     = 1'b0;

    // decoded header fields for the transaction engine
    typedef struct packed {
        logic [6:0] target_device_addr;
        logic [3:0] target_endpoint;
        tdc_dir_e   token_direction;
        logic [9:0] packet_byte_limit;
        logic [9:0] requested_byte_count;
        logic       low_speed;
        logic       isochronous;
        logic       last_entry;
        logic       once_per_frame_limiter;
        logic       toggle;
    } tdc_cmd_s;

    // outcome of one transaction, reported by the engine
    typedef struct packed {
        logic       ok;
        logic       too_much_rx_data;
        logic       short_rx_data;
        logic       memory_write_too_slow;
        logic       memory_read_too_slow;
        logic [3:0] other_code;
        logic       data_rx;
        logic [9:0] bytes_done_count;
    } tdc_res_s;

endpackage

/* design/tdc_codec.sv */
// transfer descriptor codec: header decode, per-frame gating and write-back
`timescale 1ns/1ns
module tdc_codec #(
    parameter int FRAME_CYCLES = tdc_pkg::FRAME_CYCLES
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rstn,
    // header from buffer RAM
    input  wire logic                          hdr_valid,
    input  wire logic [tdc_pkg::HDR_BITS-1:0]  hdr_in,
    // frame start from the frame timer
    input  wire logic                          frame_start,
    // result from the transaction engine
    input  wire logic                          res_valid,
    input  wire tdc_pkg::tdc_res_s             res_in,
    // command toward the transaction engine
    output logic                               cmd_valid,
    output tdc_pkg::tdc_cmd_s                  cmd_out,
    // descriptor skipped (inactive, reserved token, or limited)
    output logic                               skip_pulse,
    output logic                               list_end,
    // written-back header toward buffer RAM
    output logic                               wb_valid,
    output logic [tdc_pkg::HDR_BITS-1:0]       wb_hdr
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TDC_IDLE = 2'b00,
        TDC_BUSY = 2'b01,
        TDC_DONE = 2'b11
    } tdc_state_e;

    tdc_state_e                      state_r;
    logic [tdc_pkg::HDR_BITS-1:0]    hdr_r;
    logic                            limit_used_r;
    logic [$clog2(FRAME_CYCLES)-1:0] frame_cnt_r;
    logic                            frame_tick;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic                            in_active;
    logic                            in_once;
    logic                            in_iso;
    tdc_pkg::tdc_dir_e               in_dir;
    logic                            accept;
    logic                            blocked;
    tdc_pkg::tdc_cmd_s               dec;
    logic [3:0]                      code_nxt;

    assign in_active = hdr_in[tdc_pkg::POS_ACTIVE];
    assign in_once   = hdr_in[tdc_pkg::POS_ONCE];
    assign in_iso    = hdr_in[tdc_pkg::POS_FORMAT];
    assign in_dir    = tdc_pkg::tdc_dir_e'(hdr_in[tdc_pkg::POS_DIR +: 2]);

    // limiter only applies to non-isochronous descriptors; at a frame
    // boundary the old use no longer counts, so the first header of a frame passes
    assign blocked = in_once && !in_iso && limit_used_r && !frame_tick;
    // inactive or reserved-token descriptors are never executed
    assign accept  = hdr_valid && (state_r == TDC_IDLE) && in_active
                     && (in_dir != tdc_pkg::TDC_DIR_RSVD) && !blocked;

    // field extraction
    always_comb begin
        dec.target_device_addr     = hdr_in[tdc_pkg::POS_ADDR +: 7];
        dec.target_endpoint        = hdr_in[tdc_pkg::POS_EP +: 4];
        dec.token_direction        = in_dir;
        dec.packet_byte_limit      = {hdr_in[tdc_pkg::POS_LIMIT_HI +: 2],
                                      hdr_in[tdc_pkg::POS_LIMIT_LO +: 8]};
        dec.requested_byte_count   = {hdr_in[tdc_pkg::POS_REQ_HI +: 2],
                                      hdr_in[tdc_pkg::POS_REQ_LO +: 8]};
        dec.low_speed              = hdr_in[tdc_pkg::POS_SPEED];
        dec.isochronous            = in_iso;
        dec.last_entry             = hdr_in[tdc_pkg::POS_LAST];
        dec.once_per_frame_limiter = in_once;
        dec.toggle                 = hdr_in[tdc_pkg::POS_TOGGLE];
    end

    // result code selection; reserved codes fall back to no-error
    always_comb begin
        if (res_in.too_much_rx_data) begin
            code_nxt = tdc_pkg::RS_TOO_MUCH;
        end else if (res_in.memory_write_too_slow) begin
            code_nxt = tdc_pkg::RS_MEM_WR;
        end else if (res_in.memory_read_too_slow) begin
            code_nxt = tdc_pkg::RS_MEM_RD;
        end else if (res_in.short_rx_data) begin
            code_nxt = tdc_pkg::RS_SHORT;
        end else if (res_in.ok) begin
            code_nxt = tdc_pkg::RS_NO_ERROR;
        end else if (res_in.other_code == tdc_pkg::RS_RSVD_A ||
                     res_in.other_code == tdc_pkg::RS_RSVD_B) begin
            code_nxt = tdc_pkg::RS_NO_ERROR;
        end else begin
            code_nxt = res_in.other_code;
        end
    end

    // ------------------------------------------------------------
    // frame timer: free-running 1 ms, resynced by frame_start
    // ------------------------------------------------------------
    assign frame_tick = frame_start || (frame_cnt_r == ($clog2(FRAME_CYCLES))'(FRAME_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (!rstn || frame_tick) begin
            frame_cnt_r <= '0;
        end else begin
            frame_cnt_r <= frame_cnt_r + 1'b1;
        end
    end

    // one limited transaction per frame; a use in the tick cycle belongs to the
    // new frame, so the set wins over the clear
    always_ff @(posedge clock) begin
        if (!rstn) begin
            limit_used_r <= 1'b0;
        end else if (accept && in_once && !in_iso) begin
            limit_used_r <= 1'b1;
        end else if (frame_tick) begin
            limit_used_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= TDC_IDLE;
        end else begin
            case (state_r)
                TDC_IDLE: if (accept) state_r <= TDC_BUSY;
                TDC_BUSY: if (res_valid) state_r <= TDC_DONE;
                TDC_DONE: state_r <= TDC_IDLE;
                default:  state_r <= TDC_IDLE;
            endcase
        end
    end

    // latch header, then merge write-back fields
    always_ff @(posedge clock) begin
        if (!rstn) begin
            hdr_r <= '0;
        end else if (accept) begin
            hdr_r <= hdr_in;
        end else if (state_r == TDC_BUSY && res_valid) begin
            hdr_r[tdc_pkg::POS_DONE_LO +: 8] <= res_in.bytes_done_count[7:0];
            hdr_r[tdc_pkg::POS_DONE_HI +: 2] <= res_in.bytes_done_count[9:8];
            hdr_r[tdc_pkg::POS_STATUS +: 4]  <= code_nxt;
            hdr_r[tdc_pkg::POS_ACTIVE]       <= 1'b0;
            if (res_in.data_rx) begin
                hdr_r[tdc_pkg::POS_TOGGLE] <= ~hdr_r[tdc_pkg::POS_TOGGLE];
            end
        end
    end

    // command outputs
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmd_valid <= 1'b0;
            cmd_out   <= '0;
        end else begin
            cmd_valid <= accept;
            if (accept) begin
                cmd_out <= dec;
            end
        end
    end

    // skip and list-end pulses
    always_ff @(posedge clock) begin
        if (!rstn) begin
            skip_pulse <= 1'b0;
            list_end   <= 1'b0;
        end else begin
            skip_pulse <= hdr_valid && (state_r == TDC_IDLE) && !accept;
            list_end   <= hdr_valid && (state_r == TDC_IDLE)
                          && hdr_in[tdc_pkg::POS_LAST];
        end
    end

    // write-back pulse one cycle after the merge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wb_valid <= 1'b0;
            wb_hdr   <= '0;
        end else begin
            wb_valid <= (state_r == TDC_DONE);
            wb_hdr   <= hdr_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_active_cleared: assert property (@(posedge clock) disable iff (!rstn)
        wb_valid |-> !wb_hdr[tdc_pkg::POS_ACTIVE])
        else $error("write-back left active set");
    a_no_rsvd_code: assert property (@(posedge clock) disable iff (!rstn)
        wb_valid |-> (wb_hdr[tdc_pkg::POS_STATUS +: 4] != tdc_pkg::RS_RSVD_A &&
                      wb_hdr[tdc_pkg::POS_STATUS +: 4] != tdc_pkg::RS_RSVD_B))
        else $error("reserved result written");
    // result codes land in the write-back two cycles after the result
    a_overrun_code: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == TDC_BUSY && res_valid && res_in.too_much_rx_data)
        |-> ##2 wb_valid && wb_hdr[tdc_pkg::POS_STATUS +: 4] == tdc_pkg::RS_TOO_MUCH)
        else $error("too much data not reported");
    a_short_code: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == TDC_BUSY && res_valid && res_in.short_rx_data && !res_in.too_much_rx_data
         && !res_in.memory_write_too_slow && !res_in.memory_read_too_slow)
        |-> ##2 wb_hdr[tdc_pkg::POS_STATUS +: 4] == tdc_pkg::RS_SHORT)
        else $error("short packet not reported");
    a_memwr_code: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == TDC_BUSY && res_valid && res_in.memory_write_too_slow
         && !res_in.too_much_rx_data)
        |-> ##2 wb_hdr[tdc_pkg::POS_STATUS +: 4] == tdc_pkg::RS_MEM_WR)
        else $error("memory write stall not reported");
    a_memrd_code: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == TDC_BUSY && res_valid && res_in.memory_read_too_slow
         && !res_in.too_much_rx_data && !res_in.memory_write_too_slow)
        |-> ##2 wb_hdr[tdc_pkg::POS_STATUS +: 4] == tdc_pkg::RS_MEM_RD)
        else $error("memory read stall not reported");
    a_toggle_flip: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == TDC_BUSY && res_valid && res_in.data_rx)
        |-> ##2 wb_hdr[tdc_pkg::POS_TOGGLE] != $past(hdr_r[tdc_pkg::POS_TOGGLE], 2))
        else $error("toggle not updated");
    a_skip_inactive: assert property (@(posedge clock) disable iff (!rstn)
        (hdr_valid && state_r == TDC_IDLE && !in_active) |=> skip_pulse && !cmd_valid)
        else $error("inactive descriptor executed");
    a_once_limit: assert property (@(posedge clock) disable iff (!rstn)
        (hdr_valid && state_r == TDC_IDLE && in_once && !in_iso && limit_used_r && !frame_tick)
        |=> skip_pulse && !cmd_valid)
        else $error("second limited transaction in frame");
    a_limit_used: assert property (@(posedge clock) disable iff (!rstn)
        (accept && in_once && !in_iso) |=> limit_used_r)
        else $error("limited transaction not recorded");
    a_frame_clear: assert property (@(posedge clock) disable iff (!rstn)
        (frame_tick && !(accept && in_once && !in_iso)) |=> !limit_used_r)
        else $error("frame boundary left limiter used");

    // decoded fields follow the header as it stood at the accept edge
    a_cmd_fields: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_valid
                   && cmd_out.target_device_addr == $past(hdr_in[tdc_pkg::POS_ADDR +: 7]))
        else $error("device address mismatch");
    a_cmd_endpoint: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.target_endpoint == $past(hdr_in[tdc_pkg::POS_EP +: 4]))
        else $error("endpoint mismatch");
    a_cmd_direction: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.token_direction == $past(hdr_in[tdc_pkg::POS_DIR +: 2]))
        else $error("direction token mismatch");
    a_cmd_limit: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.packet_byte_limit == $past({hdr_in[tdc_pkg::POS_LIMIT_HI +: 2],
                                                       hdr_in[tdc_pkg::POS_LIMIT_LO +: 8]}))
        else $error("packet byte limit mismatch");
    a_cmd_count: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.requested_byte_count == $past({hdr_in[tdc_pkg::POS_REQ_HI +: 2],
                                                          hdr_in[tdc_pkg::POS_REQ_LO +: 8]}))
        else $error("requested byte count mismatch");
    a_cmd_speed: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.low_speed == $past(hdr_in[tdc_pkg::POS_SPEED]))
        else $error("speed bit mismatch");
    a_cmd_format: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.isochronous == $past(hdr_in[tdc_pkg::POS_FORMAT]))
        else $error("format bit mismatch");
    a_cmd_toggle: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.toggle == $past(hdr_in[tdc_pkg::POS_TOGGLE]))
        else $error("toggle bit mismatch");
    a_cmd_limiter: assert property (@(posedge clock) disable iff (!rstn)
        accept |=> cmd_out.once_per_frame_limiter == $past(hdr_in[tdc_pkg::POS_ONCE]))
        else $error("limiter bit mismatch");

    // reserved tokens never reach the engine; the last flag shows for any header offered while idle
    a_rsvd_token: assert property (@(posedge clock) disable iff (!rstn)
        (hdr_valid && state_r == TDC_IDLE && hdr_in[tdc_pkg::POS_DIR +: 2] == tdc_pkg::TDC_DIR_RSVD)
        |=> skip_pulse && !cmd_valid)
        else $error("reserved token executed");
    a_last_flag: assert property (@(posedge clock) disable iff (!rstn)
        (hdr_valid && state_r == TDC_IDLE && hdr_in[tdc_pkg::POS_LAST]) |=> list_end)
        else $error("last descriptor not flagged");

    // write-back lands two cycles after the result, with the engine's byte count
    a_wb_timing: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == TDC_BUSY && res_valid) |-> ##2 wb_valid)
        else $error("write-back missing");
    a_done_count: assert property (@(posedge clock) disable iff (!rstn)
        (state_r == TDC_BUSY && res_valid) |-> ##2
        {wb_hdr[tdc_pkg::POS_DONE_HI +: 2], wb_hdr[tdc_pkg::POS_DONE_LO +: 8]}
        == $past(res_in.bytes_done_count, 2))
        else $error("done byte count mismatch");

    c_full_txn: cover property (@(posedge clock) disable iff (!rstn) accept ##[1:20] wb_valid);
    c_skip:     cover property (@(posedge clock) disable iff (!rstn) skip_pulse);
    c_last:     cover property (@(posedge clock) disable iff (!rstn) list_end && cmd_valid);
    c_limited:  cover property (@(posedge clock) disable iff (!rstn) skip_pulse && limit_used_r);
    c_iso_txn:  cover property (@(posedge clock) disable iff (!rstn)
        cmd_valid && cmd_out.isochronous);

endmodule

/* verification/tdc_engine_model.sv */
// transaction engine model: answers each accepted command with one planned result
`timescale 1ns/1ns
module tdc_engine_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // command side
    input  wire logic        cmd_valid,
    // plan set by the bench
    input  wire logic [7:0]  delay_cycles,
    input  tdc_pkg::tdc_res_s res_plan,
    // result side
    output logic             res_valid,
    output tdc_pkg::tdc_res_s res_in
);
    logic [7:0] wait_r;
    logic       busy_r;

    // ------------------------------------------------------------
    // one result per command, after a programmable wait
    // ------------------------------------------------------------
    // idle result lines keep changing so a stale value is never mistaken for an answer
    always_ff @(posedge clock) begin
        if (!rstn) begin
            busy_r    <= 1'b0;
            wait_r    <= 8'h00;
            res_valid <= 1'b0;
            res_in    <= '0;
        end else begin
            res_valid <= 1'b0;
            res_in    <= ~res_in;
            if (cmd_valid) begin
                busy_r <= 1'b1;
                wait_r <= delay_cycles;
            end else if (busy_r && wait_r == 8'h00) begin
                busy_r    <= 1'b0;
                res_valid <= 1'b1;
                res_in    <= res_plan;
            end else if (busy_r) begin
                wait_r <= wait_r - 8'h01;
            end
        end
    end
endmodule

/* verification/tdc_codec_bench.sv */
// self-checking bench for the transfer descriptor codec
`timescale 1ns/1ns
module tdc_codec_bench;
    logic              clock, rstn, hdr_valid, frame_start, res_valid;
    logic              cmd_valid, skip_pulse, list_end, wb_valid;
    logic [63:0]       hdr_in, wb_hdr;
    logic [7:0]        delay_cycles;
    tdc_pkg::tdc_res_s res_in, res_plan;
    tdc_pkg::tdc_cmd_s cmd_out;
    int                err_count, checks;

    tdc_codec #(.FRAME_CYCLES(50)) dut (.clock(clock), .rstn(rstn), .hdr_valid(hdr_valid),
        .hdr_in(hdr_in), .frame_start(frame_start), .res_valid(res_valid), .res_in(res_in),
        .cmd_valid(cmd_valid), .cmd_out(cmd_out), .skip_pulse(skip_pulse),
        .list_end(list_end), .wb_valid(wb_valid), .wb_hdr(wb_hdr));
    tdc_engine_model engine (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
        .delay_cycles(delay_cycles), .res_plan(res_plan), .res_valid(res_valid),
        .res_in(res_in));

    // ------------------------------------------------------------
    // clock, compare and closing
    // ------------------------------------------------------------
    initial clock = 1'b0;
    always #2 clock = ~clock;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // header and result builders, laid out byte by byte
    // ------------------------------------------------------------
    function automatic logic [63:0] mkh(logic act, logic tog, logic once, logic fmt, logic last,
        logic spd, logic [1:0] dir, logic [9:0] lim, logic [9:0] req, logic [6:0] addr,
        logic [3:0] ep);
        return {8'h00, fmt, addr, 2'b00, once, 1'b0, dir, req, ep, last, spd, lim,
                4'h0, act, tog, 10'h000};
    endfunction

    function automatic tdc_pkg::tdc_res_s mkres(logic [4:0] f, logic [3:0] oc, logic rx,
        logic [9:0] n);
        tdc_pkg::tdc_res_s r;
        r = '0;
        {r.ok, r.too_much_rx_data, r.short_rx_data, r.memory_write_too_slow,
         r.memory_read_too_slow} = f;
        r.other_code = oc;
        r.data_rx = rx;
        r.bytes_done_count = n;
        return r;
    endfunction

    // ------------------------------------------------------------
    // shared transfer steps
    // ------------------------------------------------------------
    task automatic offer(input logic [63:0] h, output logic took, output logic skipped,
        output logic ended);
        took = 1'b0;
        skipped = 1'b0;
        ended = 1'b0;
        hdr_in = h;
        hdr_valid = 1'b1;
        @(negedge clock);
        hdr_valid = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (cmd_valid === 1'b1) took = 1'b1;
            if (skip_pulse === 1'b1) skipped = 1'b1;
            if (list_end === 1'b1) ended = 1'b1;
            @(negedge clock);
        end
    endtask

    // bounded wait for the written-back header; unknown if it never comes
    task automatic wait_wb(output logic [63:0] wb);
        wb = 'x;
        for (int i = 0; i < 100; i++) begin
            if (wb_valid === 1'b1) begin
                wb = wb_hdr;
                break;
            end
            @(negedge clock);
        end
    endtask

    task automatic txn(input logic [63:0] h, input tdc_pkg::tdc_res_s p, output logic took,
        output logic [63:0] wb);
        logic s, e;
        res_plan = p;
        offer(h, took, s, e);
        wait_wb(wb);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic limiter_test();
        logic [63:0] h, wb;
        logic t, s, e;
        h = mkh(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'b01, 10'h040, 10'h010, 7'h05, 4'h1);
        txn(h, mkres(5'h10, 4'h0, 1'b0, 10'h010), t, wb);
        check(t, 1'b1, "limited header taken after reset");
        check(cmd_out.once_per_frame_limiter, 1'b1, "limiter bit decoded");
        offer(h, t, s, e);
        check({t, s}, 2'b01, "second limited header in frame");
        frame_start = 1'b1;
        @(negedge clock);
        frame_start = 1'b0;
        txn(h, mkres(5'h10, 4'h0, 1'b0, 10'h010), t, wb);
        check(t, 1'b1, "limited header after new frame");
        // isochronous descriptors are never limited, even right after a limited one
        h[tdc_pkg::POS_FORMAT] = 1'b1;
        txn(h, mkres(5'h10, 4'h0, 1'b0, 10'h010), t, wb);
        check(t, 1'b1, "isochronous header not limited");
    endtask

    task automatic decode_test();
        logic [63:0] h, wb;
        logic t, s, e;
        res_plan = mkres(5'h10, 4'h0, 1'b0, 10'h001);
        for (int d = 0; d < 3; d++) begin
            h = mkh(1'b1, d[0], 1'b0, d[0], d == 2, d[1], d[1:0], 10'h3FF - d, 10'h201 + d,
                    7'h7F - d, 4'hF - d);
            offer(h, t, s, e);
            check(t, 1'b1, "token accepted");
            check(cmd_out.token_direction, d[1:0], "direction");
            check(cmd_out.target_device_addr, 7'h7F - d, "address");
            check(cmd_out.target_endpoint, 4'hF - d, "endpoint");
            check(cmd_out.packet_byte_limit, 10'h3FF - d, "packet limit");
            check(cmd_out.requested_byte_count, 10'h201 + d, "requested count");
            check(cmd_out.low_speed, d[1], "speed");
            check(cmd_out.isochronous, d[0], "format");
            check(cmd_out.toggle, d[0], "toggle passed to engine");
            check({cmd_out.last_entry, e}, {2{d == 2}}, "last entry");
            wait_wb(wb);
        end
    endtask

    task automatic codes_test();
        logic [4:0]  fl [9] = '{5'h08, 5'h02, 5'h01, 5'h04, 5'h10, 5'h00, 5'h00, 5'h0C, 5'h00};
        logic [3:0]  oc [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hA, 4'hB, 4'h0, 4'h4};
        logic [3:0]  ex [9] = '{4'h8, 4'hC, 4'hD, 4'h9, 4'h0, 4'h0, 4'h0, 4'h8, 4'h4};
        logic [63:0] h, wb;
        logic        t, tog, rx;
        for (int i = 0; i < 9; i++) begin
            tog = i[0];
            rx = i[1];
            delay_cycles = 8'(i * 3);
            h = mkh(1'b1, tog, 1'b0, 1'b0, 1'b0, 1'b0, 2'b10, 10'h040, 10'h100, 7'h11, 4'h2);
            txn(h, mkres(fl[i], oc[i], rx, 10'h2C0 + i), t, wb);
            check(wb[15:12], ex[i], "result status");
            check(wb[11], 1'b0, "active after completion");
            check(wb[10], tog ^ rx, "toggle after packet");
            check(wb[9:0], 10'h2C0 + i, "bytes done");
            check(wb[63:16], h[63:16], "untouched header bytes");
        end
    endtask

    task automatic skip_test();
        logic t, s, e;
        offer(mkh(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b01, 10'h8, 10'h8, 7'h3, 4'h1), t, s, e);
        check({t, s}, 2'b01, "inactive header skipped");
        offer(mkh(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11, 10'h8, 10'h8, 7'h3, 4'h1), t, s, e);
        check({t, s}, 2'b01, "reserved token skipped");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        err_count = 0;
        checks = 0;
        rstn = 1'b0;
        hdr_valid = 1'b0;
        hdr_in = '0;
        frame_start = 1'b0;
        delay_cycles = 8'h06;
        res_plan = '0;
        repeat (10) @(negedge clock);
        rstn = 1'b1;
        check({cmd_valid, skip_pulse, list_end, wb_valid}, 4'h0, "reset outputs");
        check(cmd_out.once_per_frame_limiter, 1'b0, "limiter bit after reset");
        limiter_test();
        decode_test();
        codes_test();
        skip_test();
        wrap_up();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        wrap_up();
    end
endmodule
